// File: include/celf_pkg.sv
// Constants for the channel enable latches and link fault block.
// Assumes a single pclk domain and an APB slave with 32-bit data.
package celf_pkg;
  // Structure
  localparam int CELF_NUM_CH = 4;
  localparam int CELF_BUS_W = 8;
  localparam int CELF_ADDR_W = 8;
  localparam int CELF_EVT_W = 7;
  // Register byte offsets
  localparam logic [7:0] CELF_OFF_STATUS = 8'h00;
  localparam logic [7:0] CELF_OFF_CLEAR = 8'h04;
  localparam logic [7:0] CELF_OFF_ENABLE = 8'h08;
  localparam logic [7:0] CELF_OFF_LATCH = 8'h0C;
  localparam logic [7:0] CELF_OFF_COND = 8'h10;
  // Event bit positions in status, clear and enable
  localparam int CELF_EV_FAULT = 0;
  localparam int CELF_EV_DRIVE = 4;
  localparam int CELF_EV_SELFTEST = 5;
  localparam int CELF_EV_RXPWR = 6;
  // Field positions in the latch readback register
  localparam int CELF_LAT_DRIVE = 0;
  localparam int CELF_LAT_SELFTEST = 8;
  localparam int CELF_LAT_RXPWR = 16;
  // Fixed bit-to-channel assignment on the shared enable bus
  localparam int CELF_TX_ST_BASE = 0;
  localparam int CELF_RX_ST_BASE = 4;
  localparam int CELF_RXPWR_BASE = 0;
  // Reset and pull-up values
  localparam logic [7:0] CELF_DRIVE_RST = 8'hFF;
  localparam logic [7:0] CELF_SELFTEST_RST = 8'hFF;
  localparam logic [7:0] CELF_RXPWR_RST = 8'hFF;
  localparam logic [7:0] CELF_BUS_PULLUP = 8'hFF;
  localparam logic CELF_PIN_PULLUP = 1'b1;
  localparam logic [6:0] CELF_EVT_ZERO = 7'h00;
endpackage

// File: rtl/celf_top.sv
// Channel enable latches, link fault outputs and their APB register view.
// Assumes pins arrive asynchronously and are synchronised here on pclk.
`timescale 1ns/1ps
module celf_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [celf_pkg::CELF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Latch pins
  input wire logic drive_enable_latch_open,
  input wire logic selftest_latch_open,
  input wire logic rx_power_latch_open,
  input wire logic [celf_pkg::CELF_BUS_W-1:0] shared_enable_bus,
  input wire logic device_reset_n,
  // Receive quality conditions per channel
  input wire logic [celf_pkg::CELF_NUM_CH-1:0] rx_freq_out_of_range,
  input wire logic [celf_pkg::CELF_NUM_CH-1:0] rx_amplitude_low,
  input wire logic [celf_pkg::CELF_NUM_CH-1:0] rx_density_low,
  // Channel controls
  output logic [celf_pkg::CELF_BUS_W-1:0] serial_out_driver,
  output logic [celf_pkg::CELF_NUM_CH-1:0] tx_selftest_on,
  output logic [celf_pkg::CELF_NUM_CH-1:0] rx_selftest_on,
  output logic [celf_pkg::CELF_NUM_CH-1:0] rx_power_en,
  // Link fault outputs
  output logic link_fault_n_a,
  output logic link_fault_n_b,
  output logic link_fault_n_c,
  output logic link_fault_n_d
);
  import celf_pkg::*;

  typedef struct packed {
    logic oe_s1;
    logic oe_s2;
    logic oe_prev;
    logic st_s1;
    logic st_s2;
    logic st_prev;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic rst_s1;
    logic rst_s2;
    logic [CELF_BUS_W-1:0] bus_s1;
    logic [CELF_BUS_W-1:0] bus_s2;
    logic [3*CELF_NUM_CH-1:0] cond_s1;
    logic [3*CELF_NUM_CH-1:0] cond_s2;
    logic [CELF_NUM_CH-1:0] cond_q;
    logic [CELF_NUM_CH-1:0] fault_prev;
    logic [CELF_BUS_W-1:0] drive_q;
    logic [CELF_BUS_W-1:0] selftest_q;
    logic [CELF_BUS_W-1:0] rxpwr_q;
    logic [CELF_EVT_W-1:0] status_q;
    logic [CELF_EVT_W-1:0] enable_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
  } celf_state_s;

  celf_state_s st_q;
  celf_state_s st_d;
  logic [CELF_NUM_CH-1:0] fault_now;
  logic [CELF_NUM_CH-1:0] rx_en;

  // Receive power enables under the fixed mapping
  assign rx_en = st_q.rxpwr_q[CELF_RXPWR_BASE +: CELF_NUM_CH];

  // Fault: registered conditions OR the direct disabled term
  assign fault_now = st_q.cond_q | ~rx_en;

  // Next-state logic
  always_comb begin
    logic wr;
    logic rd_setup;
    logic [CELF_EVT_W-1:0] evt;
    logic [CELF_EVT_W-1:0] clr;
    wr = psel & penable & pwrite;
    rd_setup = psel & ~penable;
    evt = CELF_EVT_ZERO;
    clr = CELF_EVT_ZERO;
    st_d = st_q;
    // Two-flop synchronisers for all pins
    st_d.oe_s1 = drive_enable_latch_open;
    st_d.oe_s2 = st_q.oe_s1;
    st_d.st_s1 = selftest_latch_open;
    st_d.st_s2 = st_q.st_s1;
    st_d.rx_s1 = rx_power_latch_open;
    st_d.rx_s2 = st_q.rx_s1;
    st_d.rst_s1 = device_reset_n;
    st_d.rst_s2 = st_q.rst_s1;
    st_d.bus_s1 = shared_enable_bus;
    st_d.bus_s2 = st_q.bus_s1;
    st_d.cond_s1 = {rx_density_low, rx_amplitude_low, rx_freq_out_of_range};
    st_d.cond_s2 = st_q.cond_s1;
    st_d.oe_prev = st_q.oe_s2;
    st_d.st_prev = st_q.st_s2;
    st_d.rx_prev = st_q.rx_s2;
    // Quality conditions retimed on the block clock
    st_d.cond_q = st_q.cond_s2[0 +: CELF_NUM_CH] | st_q.cond_s2[CELF_NUM_CH +: CELF_NUM_CH]
      | st_q.cond_s2[2*CELF_NUM_CH +: CELF_NUM_CH];
    st_d.fault_prev = fault_now;
    // Drive enable latch: open follows bus, closed holds or resets
    if (st_q.oe_s2) begin
      st_d.drive_q = st_q.bus_s2;
    end else if (!st_q.rst_s2) begin
      st_d.drive_q = CELF_DRIVE_RST;
    end
    // Self-test latch
    if (st_q.st_s2) begin
      st_d.selftest_q = st_q.bus_s2;
    end else if (!st_q.rst_s2) begin
      st_d.selftest_q = CELF_SELFTEST_RST;
    end
    // Receive power latch
    if (st_q.rx_s2) begin
      st_d.rxpwr_q = st_q.bus_s2;
    end else if (!st_q.rst_s2) begin
      st_d.rxpwr_q = CELF_RXPWR_RST;
    end
    // Events: new fault per channel and each latch closing
    evt[CELF_EV_FAULT +: CELF_NUM_CH] = fault_now & ~st_q.fault_prev;
    evt[CELF_EV_DRIVE] = st_q.oe_prev & ~st_q.oe_s2;
    evt[CELF_EV_SELFTEST] = st_q.st_prev & ~st_q.st_s2;
    evt[CELF_EV_RXPWR] = st_q.rx_prev & ~st_q.rx_s2;
    // Register writes
    if (wr && paddr == CELF_OFF_CLEAR) begin
      clr = pwdata[CELF_EVT_W-1:0];
    end
    if (wr && paddr == CELF_OFF_ENABLE) begin
      st_d.enable_q = pwdata[CELF_EVT_W-1:0];
    end
    // Sticky status, a new event beats a clear
    st_d.status_q = (st_q.status_q & ~clr) | evt;
    // Read data and error captured in the setup cycle
    if (rd_setup) begin
      st_d.prdata_q = 32'h0000_0000;
      st_d.pslverr_q = 1'b0;
      unique case (paddr)
        CELF_OFF_STATUS: st_d.prdata_q[CELF_EVT_W-1:0] = st_q.status_q;
        CELF_OFF_CLEAR: st_d.prdata_q = 32'h0000_0000;
        CELF_OFF_ENABLE: st_d.prdata_q[CELF_EVT_W-1:0] = st_q.enable_q;
        CELF_OFF_LATCH: begin
          st_d.prdata_q[CELF_LAT_DRIVE +: CELF_BUS_W] = st_q.drive_q;
          st_d.prdata_q[CELF_LAT_SELFTEST +: CELF_BUS_W] = st_q.selftest_q;
          st_d.prdata_q[CELF_LAT_RXPWR +: CELF_BUS_W] = st_q.rxpwr_q;
        end
        CELF_OFF_COND: st_d.prdata_q[CELF_NUM_CH-1:0] = st_q.cond_q;
        default: st_d.pslverr_q = 1'b1;
      endcase
    end
  end

  // State register; pins start at their pulled-up level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.oe_s1 <= CELF_PIN_PULLUP;
      st_q.oe_s2 <= CELF_PIN_PULLUP;
      st_q.oe_prev <= CELF_PIN_PULLUP;
      st_q.st_s1 <= CELF_PIN_PULLUP;
      st_q.st_s2 <= CELF_PIN_PULLUP;
      st_q.st_prev <= CELF_PIN_PULLUP;
      st_q.rx_s1 <= CELF_PIN_PULLUP;
      st_q.rx_s2 <= CELF_PIN_PULLUP;
      st_q.rx_prev <= CELF_PIN_PULLUP;
      st_q.rst_s1 <= CELF_PIN_PULLUP;
      st_q.rst_s2 <= CELF_PIN_PULLUP;
      st_q.bus_s1 <= CELF_BUS_PULLUP;
      st_q.bus_s2 <= CELF_BUS_PULLUP;
      st_q.drive_q <= CELF_DRIVE_RST;
      st_q.selftest_q <= CELF_SELFTEST_RST;
      st_q.rxpwr_q <= CELF_RXPWR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // APB answers with no wait state
  assign pready = 1'b1;
  assign prdata = st_q.prdata_q;
  assign pslverr = st_q.pslverr_q;
  assign irq = |(st_q.status_q & st_q.enable_q);

  // Channel controls; low selection bit means self-test
  assign serial_out_driver = st_q.drive_q;
  assign tx_selftest_on = ~st_q.selftest_q[CELF_TX_ST_BASE +: CELF_NUM_CH];
  assign rx_selftest_on = ~st_q.selftest_q[CELF_RX_ST_BASE +: CELF_NUM_CH];
  assign rx_power_en = rx_en;

  // Active-low fault pins
  assign link_fault_n_a = ~fault_now[0];
  assign link_fault_n_b = ~fault_now[1];
  assign link_fault_n_c = ~fault_now[2];
  assign link_fault_n_d = ~fault_now[3];

  // Checks
  sequence s_oe_fall;
    st_q.oe_s2 ##1 !st_q.oe_s2;
  endsequence
  sequence s_st_fall;
    st_q.st_s2 ##1 !st_q.st_s2;
  endsequence
  sequence s_rx_fall;
    st_q.rx_s2 ##1 !st_q.rx_s2;
  endsequence

  a_drive_follows_bus: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.oe_s2 |=> serial_out_driver == $past(st_q.bus_s2))
    else $error("drive enables do not follow bus while open");
  a_drive_capture_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_oe_fall ##0 st_q.rst_s2 ##1 (!st_q.oe_s2 && st_q.rst_s2)
      |-> serial_out_driver == $past(st_q.bus_s2, 2))
    else $error("drive latch lost captured value");
  a_drive_reset_all: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st_q.oe_s2 && !st_q.rst_s2) |=> serial_out_driver == CELF_DRIVE_RST)
    else $error("drive latch not reset to all enabled");
  a_selftest_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.st_s2 |=> rx_selftest_on == ~$past(st_q.bus_s2[CELF_RX_ST_BASE +: CELF_NUM_CH]))
    else $error("self-test selection does not follow bus");
  a_selftest_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_st_fall ##0 st_q.rst_s2 |-> tx_selftest_on
      == ~$past(st_q.bus_s2[CELF_TX_ST_BASE +: CELF_NUM_CH]))
    else $error("self-test latch did not capture");
  a_selftest_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st_q.st_s2 && !st_q.rst_s2) |=> (tx_selftest_on == '0 && rx_selftest_on == '0))
    else $error("self-test not disabled by reset");
  a_rxpwr_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_rx_fall ##0 st_q.rst_s2 |-> rx_power_en
      == $past(st_q.bus_s2[CELF_RXPWR_BASE +: CELF_NUM_CH]))
    else $error("receive power latch did not capture");
  a_rxpwr_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st_q.rx_s2 && !st_q.rst_s2) |=> rx_power_en == '1)
    else $error("receivers not enabled by reset");
  a_fault_cond_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.cond_s2[0] && rx_en[0]) |=> !link_fault_n_a)
    else $error("frequency fault did not reach output in one cycle");
  a_fault_disabled: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rx_power_en[1] |-> !link_fault_n_b)
    else $error("disabled channel shows no fault");
  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.status_q[CELF_EV_DRIVE] && st_q.enable_q[CELF_EV_DRIVE]) |-> irq)
    else $error("enabled event gives no interrupt");

  // Open latches track the bus, closed ones hold
  a_rxpwr_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.rx_s2 |=> rx_power_en == $past(st_q.bus_s2[CELF_RXPWR_BASE +: CELF_NUM_CH]))
    else $error("receive power does not follow bus while open");
  a_selftest_tx_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.st_s2 |=> tx_selftest_on == ~$past(st_q.bus_s2[CELF_TX_ST_BASE +: CELF_NUM_CH]))
    else $error("transmit self-test does not follow bus");
  a_drive_hold_closed: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st_q.oe_s2 && st_q.rst_s2) |=> serial_out_driver == $past(serial_out_driver))
    else $error("closed drive latch changed");
  a_selftest_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st_q.st_s2 && st_q.rst_s2) |=> tx_selftest_on == $past(tx_selftest_on))
    else $error("closed self-test latch changed");
  a_rxpwr_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st_q.rx_s2 && st_q.rst_s2) |=> rx_power_en == $past(rx_power_en))
    else $error("closed receive power latch changed");

  // Each quality condition reaches its own pin
  a_fault_amp_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.cond_s2[CELF_NUM_CH+1] && rx_en[1]) |=> !link_fault_n_b)
    else $error("amplitude fault did not reach output");
  a_fault_dens_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.cond_s2[2*CELF_NUM_CH+2] && rx_en[2]) |=> !link_fault_n_c)
    else $error("density fault did not reach output");
  a_fault_clear_pin: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st_q.cond_s2[3] && !st_q.cond_s2[7] && !st_q.cond_s2[11]) ##1 rx_en[3]
      |-> link_fault_n_d)
    else $error("fault pin low with no condition");

  // Latch closing events and sticky status
  a_drive_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_oe_fall |=> st_q.status_q[CELF_EV_DRIVE])
    else $error("drive latch close not recorded");
  a_selftest_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_st_fall |=> st_q.status_q[CELF_EV_SELFTEST])
    else $error("self-test latch close not recorded");
  a_rxpwr_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_rx_fall |=> st_q.status_q[CELF_EV_RXPWR])
    else $error("receive power latch close not recorded");
  a_status_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.status_q[CELF_EV_DRIVE] && !(psel && penable && pwrite && paddr == CELF_OFF_CLEAR))
      |=> st_q.status_q[CELF_EV_DRIVE])
    else $error("status bit lost without a clear");
  a_status_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == CELF_OFF_CLEAR && pwdata[CELF_EV_DRIVE]
      && !(st_q.oe_prev && !st_q.oe_s2)) |=> !st_q.status_q[CELF_EV_DRIVE])
    else $error("status bit not cleared");
  a_irq_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((st_q.status_q & st_q.enable_q) == CELF_EVT_ZERO) |-> !irq)
    else $error("interrupt with no enabled event");

  // Register reads answer from the setup cycle
  sequence s_apb_setup;
    psel && !penable;
  endsequence
  a_read_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_apb_setup ##0 paddr == CELF_OFF_LATCH |=> prdata[7:0] == $past(serial_out_driver))
    else $error("latch readback wrong");
  a_read_status: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_apb_setup ##0 paddr == CELF_OFF_STATUS |=> prdata[6:0] == $past(st_q.status_q))
    else $error("status readback wrong");
  a_mapped_no_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_apb_setup ##0 paddr == CELF_OFF_STATUS |=> (!pslverr && pready))
    else $error("mapped register answered with error");
endmodule

// File: bench/celf_host_model.sv
// Host logic model driving the latch strobes, the shared enable bus and device reset.
// Assumes the bench calls its tasks; pins change only just after rising pclk edges.
`timescale 1ns/1ps
module celf_host_model (
  // Clock
  input wire logic pclk,
  // Latch pins
  output logic drive_enable_latch_open,
  output logic selftest_latch_open,
  output logic rx_power_latch_open,
  output logic [celf_pkg::CELF_BUS_W-1:0] shared_enable_bus,
  output logic device_reset_n
);
  import celf_pkg::*;
  // Idle pins: strobes low, bus released to its pull-up level
  initial begin
    {rx_power_latch_open, selftest_latch_open, drive_enable_latch_open} = 3'h0;
    shared_enable_bus = CELF_BUS_PULLUP;
    device_reset_n = 1'b1;
  end
  // Open one latch only, bus value then stands four cycles
  task automatic open_latch(input int sel, input logic [7:0] v);
    @(posedge pclk);
    shared_enable_bus <= v;
    {rx_power_latch_open, selftest_latch_open, drive_enable_latch_open} <= 3'(1 << sel);
    repeat (4) @(posedge pclk);
  endtask
  // Close, hold the bus past the fall, then release it
  task automatic close_latch();
    @(posedge pclk);
    {rx_power_latch_open, selftest_latch_open, drive_enable_latch_open} <= 3'h0;
    repeat (4) @(posedge pclk);
    shared_enable_bus <= CELF_BUS_PULLUP;
    repeat (4) @(posedge pclk);
  endtask
  // Device reset held low for five cycles
  task automatic pulse_reset();
    @(posedge pclk);
    device_reset_n <= 1'b0;
    repeat (5) @(posedge pclk);
    device_reset_n <= 1'b1;
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the channel enable latches and link fault block.
// Assumes the host model owns the latch pins; the bench drives APB and conditions.
`timescale 1ns/1ps
module tb;
  import celf_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, irq, drive_enable_latch_open, selftest_latch_open;
  logic rx_power_latch_open, device_reset_n;
  logic [7:0] paddr = 8'h00, shared_enable_bus, serial_out_driver;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [11:0] cond = 12'h000;
  logic [3:0] tx_selftest_on, rx_selftest_on, rx_power_en;
  wire [3:0] lf;
  wire [7:0] st = {rx_selftest_on, tx_selftest_on};
  int miscompares, cmp_count, cyc;
  // Block clock, 40 ns period
  always #20 pclk = ~pclk;
  // Design and host model
  celf_top dut (.*, .rx_freq_out_of_range(cond[11:8]), .rx_amplitude_low(cond[7:4]),
    .rx_density_low(cond[3:0]), .link_fault_n_a(lf[0]), .link_fault_n_b(lf[1]),
    .link_fault_n_c(lf[2]), .link_fault_n_d(lf[3]));
  celf_host_model host (.*);
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Counts, verdict and end of run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; read data taken at the edge where pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Hang guard
  always @(posedge pclk) if (++cyc == 5000) begin
    miscompares++;
    stop_test();
  end
  task automatic t_drive();
    chk("reset", {serial_out_driver, st, rx_power_en, lf}, 24'hFF00FF);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", pslverr, 1'b1);
    apb(1'b1, CELF_OFF_CLEAR, 32'h7F);
    apb(1'b1, CELF_OFF_ENABLE, 32'h1 << CELF_EV_DRIVE);
    host.open_latch(0, 8'hA5);
    chk("drive open", serial_out_driver, 8'hA5);
    host.close_latch();
    chk("drive held", {irq, serial_out_driver}, 9'h1A5);
    apb(1'b0, CELF_OFF_LATCH, 32'h0);
    chk("latch reg", rd, 32'h00FFFFA5);
    apb(1'b0, CELF_OFF_STATUS, 32'h0);
    chk("status reg", rd, 32'h10);
    apb(1'b0, CELF_OFF_ENABLE, 32'h0);
    chk("enable reg", rd, 32'h10);
    apb(1'b1, CELF_OFF_CLEAR, 32'h7F);
    apb(1'b1, CELF_OFF_ENABLE, 32'h0);
    chk("irq cleared", irq, 1'b0);
    $display("t_drive done");
  endtask
  task automatic t_selftest();
    host.open_latch(1, 8'h5A);
    chk("selftest open", st, 8'hA5);
    host.close_latch();
    chk("selftest held", {irq, st}, 9'h0A5);
    $display("t_selftest done");
  endtask
  task automatic t_power();
    host.open_latch(2, 8'hF6);
    chk("power open", {rx_power_en, lf}, 8'h66);
    host.close_latch();
    chk("power held", {rx_power_en, lf}, 8'h66);
    host.open_latch(2, 8'hFF);
    host.close_latch();
    for (int b = 0; b < 12; b++) begin
      @(posedge pclk);
      cond <= 12'h1 << b;
      repeat (4) @(posedge pclk);
      chk("fault pin", lf, 4'hF ^ (4'h1 << (b % 4)));
      @(posedge pclk);
      cond <= 12'h000;
      repeat (4) @(posedge pclk);
    end
    chk("fault gone", lf, 4'hF);
    $display("t_power done");
  endtask
  task automatic t_devrst();
    host.open_latch(2, 8'hF0);
    host.close_latch();
    host.pulse_reset();
    repeat (4) @(posedge pclk);
    chk("device reset", {serial_out_driver, st, rx_power_en}, 20'hFF00F);
    $display("t_devrst done");
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_drive();
    t_selftest();
    t_power();
    t_devrst();
    stop_test();
  end
endmodule
